// >>> logic/udrp_arbiter.sv
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`include "udrp_consts.svh"

module udrp_arbiter
  import udrp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // endpoint data-ready levels from usb function logic (same clock)
  input  wire logic        ep1_bulk_data_port_rdy,
  input  wire logic        ep2_bulk_data_port_rdy,
  // low-active level request lines
  output logic             usb_xfer_req_line0_n,
  output logic             usb_xfer_req_line1_n,
  // granted units toward the transfer engine
  output udrp_rec_type     grant_rec,
  output logic             grant_valid,
  input  wire logic        grant_ready
);

  // ****************************************
  // declarations
  // ****************************************
  udrp_route_type  route;
  logic [6:0]      ctrl;
  logic [7:0]      count;
  logic            dph_wr;
  logic [7:0]      dph_addr;
  logic            aph_take;
  logic [31:0]     next_rdata;
  logic [3:0]      chan_req;
  logic [3:0]      usb_req;
  logic [3:0]      eff_req;
  logic [1:0]      pick;
  logic            any_req;
  udrp_state_type  state;
  logic [1:0]      cur;
  logic [7:0]      remain;
  logic [3:0]      seq;
  logic            cur_req;
  logic            cur_usb;
  logic            hold;
  logic            unit_go;
  logic            halt;
  udrp_rec_type    rec_in;
  logic            rec_ready;
  logic [7:0]      rec_bits;
  logic            line0;
  logic            line1;

  // ****************************************
  // functions
  // ****************************************

  // route field to line, reserved and none give nothing
  // 01 is reserved; it is treated as off so that a stray write cannot
  // raise a request line
  function automatic logic [1:0] route_lines(input logic [1:0] sel,
                                             input logic       rdy);
    logic [1:0] lines;
    lines = 2'h0;
    unique case (sel)
      `UDRP_ROUTE_LINE0: lines = {1'b0, rdy};
      `UDRP_ROUTE_LINE1: lines = {rdy, 1'b0};
      `UDRP_ROUTE_NONE,
      `UDRP_ROUTE_RSVD:  lines = 2'h0;
    endcase
    return lines;
  endfunction

  // fixed-rank encoder, index 0 highest
  // scans from the lowest rank up, so the last hit is the highest rank
  function automatic logic [1:0] first_set(input logic [3:0] req);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (req[i])
        idx = 2'(i);
    end
    return idx;
  endfunction

  // ****************************************
  // ahb-lite slave
  // ****************************************
  // every register answers at once, so the slave never needs to stretch
  // a transfer
  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay
  assign aph_take  = hsel && hready && htrans[1];

  // latch address phase for the write data phase
  // hready low means another slave stretches the bus; hold the phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr   <= 1'b0;
      dph_addr <= 8'h00;
    end
    else if (hready)
    begin
      dph_wr   <= aph_take && hwrite;
      dph_addr <= haddr;
    end
  end

  // read mux, evaluated in the address phase
  // no read has a side effect, so decoding early is harmless
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (haddr)
      `UDRP_OFS_ROUTE:  next_rdata = {28'h0, route};
      `UDRP_OFS_CTRL:   next_rdata = {25'h0, ctrl};
      `UDRP_OFS_COUNT:  next_rdata = {24'h0, count};
      `UDRP_OFS_STATUS: next_rdata = {16'h0, remain, seq[1:0],
                                      !rec_ready, line1, line0,
                                      cur, state == ARB_OWN};
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  // read data register
  // moves only on a read, so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (aph_take && !hwrite)
      hrdata <= next_rdata;
  end

  // routing register; upper nibble has no storage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      route <= `UDRP_ROUTE_RST;
    else if (dph_wr && dph_addr == `UDRP_OFS_ROUTE)
    begin
      route.ep2 <= hwdata[`UDRP_EP2_LSB +: 2];
      route.ep1 <= hwdata[`UDRP_EP1_LSB +: 2];
    end
  end

  // control register: auto enables, full mode, burst, block
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= `UDRP_CTRL_RST;
    else if (dph_wr && dph_addr == `UDRP_OFS_CTRL)
      ctrl <= hwdata[6:0];
  end

  // units per burst or block
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= `UDRP_COUNT_RST;
    else if (dph_wr && dph_addr == `UDRP_OFS_COUNT)
      count <= hwdata[7:0];
  end

  // ****************************************
  // usb request routing
  // ****************************************

  // only the two bulk endpoints feed the lines
  // two endpoints on one line are ored; keeping them apart is software's
  always_comb
  begin
    logic [1:0] l1;
    logic [1:0] l2;
    l1 = route_lines(route.ep1, ep1_bulk_data_port_rdy);
    l2 = route_lines(route.ep2, ep2_bulk_data_port_rdy);
    line0 = l1[0] | l2[0];
    line1 = l1[1] | l2[1];
  end

  // low-active level outputs
  // registered so the lines never glitch while a route field changes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      usb_xfer_req_line0_n <= 1'b1;
      usb_xfer_req_line1_n <= 1'b1;
    end
    else
    begin
      usb_xfer_req_line0_n <= !line0;
      usb_xfer_req_line1_n <= !line1;
    end
  end

  // ****************************************
  // channel requests and ranking
  // ****************************************

  // line0 feeds 0A, line1 feeds 1A; auto enables feed all four
  // a line that is low this cycle is a live usb request in the same cycle
  assign usb_req  = {1'b0, !usb_xfer_req_line1_n,
                     1'b0, !usb_xfer_req_line0_n};
  assign chan_req = usb_req | ctrl[3:0];

  // full address mode merges A and B into one channel
  // the merged request sits at the A position of each channel
  always_comb
  begin
    if (ctrl[`UDRP_CTRL_FULL])
      eff_req = {1'b0, chan_req[3] | chan_req[2],
                 1'b0, chan_req[1] | chan_req[0]};
    else
      eff_req = chan_req;
  end

  assign any_req = |eff_req;
  assign pick    = first_set(eff_req);

  // ****************************************
  // grant sequencing
  // ****************************************
  assign cur_req = eff_req[cur];
  // in full address mode the channel's line makes it a usb source
  assign cur_usb = usb_req[cur] ||
                   (ctrl[`UDRP_CTRL_FULL] && usb_req[{cur[1], 1'b0}]);
  assign unit_go = (state == ARB_OWN) && cur_req && rec_ready;
  assign halt    = (state == ARB_OWN) && !cur_req;

  // usb-started transfers always release after each unit
  // auto bursts hold the bus only while more than one unit remains
  assign hold = !cur_usb &&
                (ctrl[`UDRP_CTRL_BURST] || ctrl[`UDRP_CTRL_BLOCK]) &&
                (remain > 8'h01);

  // arbiter state: idle means the bus is released
  // a full queue keeps the owner in place rather than losing a unit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= ARB_IDLE;
    else
    begin
      unique case (state)
        ARB_IDLE:
          if (any_req)
            state <= ARB_OWN;
        ARB_OWN:
          if (halt || (unit_go && !hold))
            state <= ARB_IDLE;
      endcase
    end
  end

  // owned channel, only chosen while the bus is free
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cur <= 2'h0;
    else if (state == ARB_IDLE && any_req)
      cur <= pick;
  end

  // units left in the current burst or block
  // a fresh count is loaded at every grant, so a halted or released
  // channel never leaves a stale count for the next owner
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      remain <= 8'h00;
    else if (state == ARB_IDLE && any_req)
      remain <= (count == 8'h00) ? 8'h01 : count;
    else if (unit_go && remain > 8'h01)
      remain <= remain - 8'h01;
    else if (unit_go)
      remain <= 8'h00;
  end

  // running sequence number for granted units
  // four bits let the consumer spot a lost or doubled unit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      seq <= 4'h0;
    else if (unit_go)
      seq <= seq + 4'h1;
  end

  // ****************************************
  // grant queue
  // ****************************************
  always_comb
  begin
    rec_in.chan    = cur;
    rec_in.usb_src = cur_usb;
    rec_in.last    = !hold;
    rec_in.seq     = seq;
  end

  // full queue stalls the owned channel
  // the queue decouples grant decisions from a slow transfer engine
  udrp_fifo #(
    .WIDTH (`UDRP_REC_WIDTH),
    .DEPTH (`UDRP_FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_data   (rec_in),
    .in_valid  (unit_go),
    .in_ready  (rec_ready),
    .out_data  (rec_bits),
    .out_valid (grant_valid),
    .out_ready (grant_ready)
  );

  // the head record goes out as stored and stands while it waits
  assign grant_rec = rec_bits;

endmodule

// >>> logic/udrp_consts.svh
`ifndef UDRP_CONSTS_SVH
`define UDRP_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define UDRP_OFS_ROUTE   8'h00
`define UDRP_OFS_CTRL    8'h04
`define UDRP_OFS_COUNT   8'h08
`define UDRP_OFS_STATUS  8'h0C

// ****************************************
// field positions and codes
// ****************************************
`define UDRP_EP1_LSB     0
`define UDRP_EP2_LSB     2
`define UDRP_ROUTE_NONE  2'h0
`define UDRP_ROUTE_RSVD  2'h1
`define UDRP_ROUTE_LINE0 2'h2
`define UDRP_ROUTE_LINE1 2'h3
`define UDRP_CTRL_FULL   4
`define UDRP_CTRL_BURST  5
`define UDRP_CTRL_BLOCK  6

// ****************************************
// reset values and sizes
// ****************************************
`define UDRP_ROUTE_RST   4'h0
`define UDRP_CTRL_RST    7'h00
`define UDRP_COUNT_RST   8'h01
`define UDRP_FIFO_DEPTH  4
`define UDRP_REC_WIDTH   8

`endif

// >>> logic/udrp_fifo.sv
module udrp_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  // honest full and empty from the fill level
  assign in_ready  = (fill < (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // storage
  always_ff @(posedge hclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (32'(wr_ptr) == DEPTH - 1) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (32'(rd_ptr) == DEPTH - 1) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        fill <= fill + 1'b1;
      else if (pop && !push)
        fill <= fill - 1'b1;
    end
  end

endmodule

// >>> logic/udrp_pkg.sv
package udrp_pkg;

  // arbiter states
  typedef enum logic
  {
    ARB_IDLE,
    ARB_OWN
  } udrp_state_type;

  // one granted unit, queued toward the transfer engine
  typedef struct packed
  {
    logic [1:0] chan;   // 0=0A 1=0B 2=1A 3=1B
    logic       usb_src;
    logic       last;   // bus released after this unit
    logic [3:0] seq;
  } udrp_rec_type;

  // routing register fields
  typedef struct packed
  {
    logic [1:0] ep2;
    logic [1:0] ep1;
  } udrp_route_type;

endpackage

// >>> test/udrp_arbiter_chk.sv
// ********
// checker
// ********
module udrp_arbiter_chk
  import udrp_pkg::*;
(
  input logic         hclk,
  input logic         hresetn,
  input logic         hsel,
  input logic [7:0]   haddr,
  input logic [1:0]   htrans,
  input logic         hwrite,
  input logic [31:0]  hwdata,
  input logic         hready,
  input logic [31:0]  hrdata,
  input logic         ep1_bulk_data_port_rdy,
  input logic         ep2_bulk_data_port_rdy,
  input logic         usb_xfer_req_line0_n,
  input logic         usb_xfer_req_line1_n,
  input udrp_rec_type grant_rec,
  input logic         grant_valid,
  input logic         grant_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr_rt;
  logic       rd_rt;
  logic [3:0] rt;
  logic       w0;
  logic       w1;
  logic       e1;
  logic       e2;

  // endpoint levels and wanted line states
  assign e1 = ep1_bulk_data_port_rdy;
  assign e2 = ep2_bulk_data_port_rdy;
  assign w0 = (rt[1:0] == 2'h2 && e1) || (rt[3:2] == 2'h2 && e2);
  assign w1 = (rt[1:0] == 2'h3 && e1) || (rt[3:2] == 2'h3 && e2);

  // data phase flags for the routing register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_rt <= 1'b0;
      rd_rt <= 1'b0;
    end
    else if (hready)
    begin
      wr_rt <= hsel && htrans[1] && hwrite && haddr == 8'h00;
      rd_rt <= hsel && htrans[1] && !hwrite && haddr == 8'h00;
    end
  end

  // mirror of the routing fields
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rt <= 4'h0;
    else if (wr_rt && hready)
      rt <= hwdata[3:0];
  end

  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_line0_route:
    assert property (usb_xfer_req_line0_n == !$past(w0))
    else $error("line0 level wrong");
  a_line1_route:
    assert property (usb_xfer_req_line1_n == !$past(w1))
    else $error("line1 level wrong");
  a_no_source:
    assert property (!e1 && !e2 |=> usb_xfer_req_line0_n
      && usb_xfer_req_line1_n) else $error("line without source");
  a_drop_halts:
    assert property ($fell(e1) && !e2 |=> usb_xfer_req_line0_n
      && usb_xfer_req_line1_n) else $error("line stays after drop");
  a_rsvd_read:
    assert property (rd_rt |-> hrdata[31:4] == 28'h0000000)
    else $error("reserved route bits set");
  a_usb_unit:
    assert property (grant_valid && grant_rec.usb_src |-> grant_rec.last)
    else $error("usb unit keeps bus");
  a_usb_chan:
    assert property (grant_valid && grant_rec.usb_src |-> !grant_rec.chan[0])
    else $error("usb unit on b channel");
  a_grant_hold:
    assert property (grant_valid && !grant_ready |=> grant_valid
      && $stable(grant_rec)) else $error("unit lost while stalled");

  c_line0: cover property (!usb_xfer_req_line0_n);
  c_line1: cover property (!usb_xfer_req_line1_n);
  c_stall: cover property (grant_valid && !grant_ready ##1 grant_valid);
endmodule

bind udrp_arbiter udrp_arbiter_chk u_chk
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .ep1_bulk_data_port_rdy(ep1_bulk_data_port_rdy),
  .ep2_bulk_data_port_rdy(ep2_bulk_data_port_rdy),
  .usb_xfer_req_line0_n(usb_xfer_req_line0_n),
  .usb_xfer_req_line1_n(usb_xfer_req_line1_n), .grant_rec(grant_rec),
  .grant_valid(grant_valid), .grant_ready(grant_ready)
);

// >>> test/udrp_far_model.sv
// ********
// usb function levels and unit consumer
// ********
module udrp_far_model
(
  input  logic hclk,
  input  logic hresetn,
  input  logic want1,
  input  logic want2,
  input  logic stall,
  input  logic slow,
  output logic ep1_rdy,
  output logic ep2_rdy,
  output logic grant_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // levels held while data waits; consumer prompt or random slow
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ep1_rdy <= 1'b0;
      ep2_rdy <= 1'b0;
      grant_ready <= 1'b0;
    end
    else
    begin
      ep1_rdy <= want1;
      ep2_rdy <= want2;
      grant_ready <= !stall && (!slow || $urandom_range(1));
    end
  end
endmodule

// >>> test/usb_dma_request_priority_tb.sv
module usb_dma_request_priority_tb;
  import udrp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [7:0]   haddr = 8'h00;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata, rd;
  logic         hreadyout, hresp, line0_n, line1_n, ep1_rdy, ep2_rdy;
  logic         grant_valid, grant_ready, have_prev = 1'b0;
  logic         want1 = 1'b0, want2 = 1'b0, stall = 1'b0, slow = 1'b0;
  udrp_rec_type grant_rec, prev;
  udrp_rec_type got[$];
  int           fails = 0, checks_done = 0, cyc = 0, usb_pops = 0;

  always #2 hclk = ~hclk;

  udrp_arbiter dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ep1_bulk_data_port_rdy(ep1_rdy),
    .ep2_bulk_data_port_rdy(ep2_rdy), .usb_xfer_req_line0_n(line0_n),
    .usb_xfer_req_line1_n(line1_n), .grant_rec(grant_rec),
    .grant_valid(grant_valid), .grant_ready(grant_ready)
  );

  udrp_far_model far
  (
    .hclk(hclk), .hresetn(hresetn), .want1(want1), .want2(want2),
    .stall(stall), .slow(slow), .ep1_rdy(ep1_rdy), .ep2_rdy(ep2_rdy),
    .grant_ready(grant_ready)
  );

  // ********
  // helpers
  // ********
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
    end
  endtask

  // one single ahb-lite transfer, read data left in rd
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // let the consumer empty the queue of units
  task automatic flush;
    stall <= 1'b0;
    slow <= 1'b0;
    repeat (4) @(posedge hclk);
    while (grant_valid !== 1'b0) @(posedge hclk);
    got.delete();
    have_prev = 1'b0;
  endtask

  // reference ranking: lowest requesting index wins
  function automatic int exp_chan(int c);
    int i = 0;
    while (i < 3 && c[i] == 0) i++;
    return c[4] ? i & 2 : i;
  endfunction

  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // collect popped units and cut a hang short
  always @(posedge hclk)
  begin
    cyc++;
    if (grant_valid === 1'b1 && grant_ready === 1'b1)
    begin
      if (have_prev)
        chk("switch", 1, prev.last || prev.chan == grant_rec.chan);
      if (have_prev)
        chk("seq", 4'(prev.seq + 4'h1), grant_rec.seq);
      got.push_back(grant_rec);
      usb_pops += grant_rec.usb_src;
      prev = grant_rec;
      have_prev = 1'b1;
    end
    if (cyc == 6000)
    begin
      fails++;
      complete_run();
    end
  end

  // ********
  // tests
  // ********
  initial
  begin
    int r, m, k, n, e0, e1;
    logic [7:0] ctl [8];
    ctl = '{8'h0F, 8'h0E, 8'h0C, 8'h08, 8'h12, 8'h18, 8'h21, 8'h43};
    void'($urandom(67507));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, 8'h00, 0);
    chk("route", 0, rd);
    chk("okay", 0, hresp);
    ahb(0, 8'h08, 0);
    chk("count", 1, rd);
    ahb(0, 8'h10, 0);
    chk("unmapped", 0, rd);
    ahb(1, 8'h00, 32'hFFFFFFFF);
    ahb(0, 8'h00, 0);
    chk("route rsvd", 32'hF, rd);
    $display("test registers done");
    slow <= 1'b1;
    for (r = 0; r < 16; r++)
    begin
      if (r[3:2] == r[1:0] && r[1]) continue;
      ahb(1, 8'h00, r);
      for (m = 0; m < 4; m++)
      begin
        want1 <= m[0];
        want2 <= m[1];
        repeat (3) @(posedge hclk);
        e0 = (r[1:0] == 2 && m[0]) || (r[3:2] == 2 && m[1]);
        e1 = (r[1:0] == 3 && m[0]) || (r[3:2] == 3 && m[1]);
        chk("line0", !e0, line0_n);
        chk("line1", !e1, line1_n);
      end
    end
    want1 <= 1'b0;
    want2 <= 1'b0;
    ahb(1, 8'h00, 32'h2);
    flush;
    usb_pops = 0;
    want1 <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("usb units", 3, usb_pops);
    ahb(0, 8'h0C, 0);
    chk("line0 stat", 1, rd[3]);
    want1 <= 1'b0;
    flush;
    usb_pops = 0;
    repeat (10) @(posedge hclk);
    chk("halted", 0, usb_pops);
    ahb(1, 8'h00, 0);
    $display("test routing done");
    ahb(1, 8'h08, 3);
    for (k = 0; k < 8; k++)
    begin
      stall <= 1'b1;
      ahb(1, 8'h04, ctl[k]);
      repeat (12) @(posedge hclk);
      ahb(0, 8'h0C, 0);
      chk("full", 1, rd[5]);
      ahb(1, 8'h04, 0);
      stall <= 1'b0;
      repeat (8) @(posedge hclk);
      chk("units", 4, got.size());
      for (n = 0; n < 4; n++)
      begin
        chk("chan", exp_chan(ctl[k]), got[n].chan);
        chk("last", ctl[k][6:5] ? n % 3 == 2 : 1, got[n].last);
      end
      flush;
    end
    $display("test ranking done");
    ahb(1, 8'h04, 32'h22);
    ahb(1, 8'h00, 32'h2);
    slow <= 1'b1;
    repeat ($urandom_range(7)) @(posedge hclk);
    usb_pops = 0;
    want1 <= 1'b1;
    repeat (30) @(posedge hclk);
    chk("preempt", 1, usb_pops > 0);
    want1 <= 1'b0;
    ahb(1, 8'h04, 0);
    ahb(1, 8'h00, 0);
    flush;
    $display("test preempt done");
    complete_run();
  end
endmodule
